// File: rtl/oee_engine.sv
// Purpose: OAM endpoint engine lookup
// Assumes: One lookup per cycle, inputs synchronous
// Notes:   Result is registered one cycle after the request
//
// Contract
// R1 - External stamping leaves stamp fields untouched
// R2 - Delay processing off: statistics only
// R3 - Delay frames counted per OAM/data enables
// R4 - Transmit: stamp forward field, bump request count
// R5 - Receive: flag, stamp, bump reply count
// R6 - Copy received delay frames when enabled
// R7 - Generic/unknown never modified, transmit inert
// R8 - Generic counted by masks, unknown by enables
// R9 - Same-level frames blocked unless pass mask
// R10 - Receive sets generic or unknown flag
// R11 - Generic/unknown CPU copy with queue choice
// R12 - Trace frames: level and address check
// R13 - Trace frames copied per type, trace queue
// R14 - Trace flags and per-type counters
// R15 - Sequence frames: 8880/0008 or UDP
// R16 - Classifier tags sequence frames beforehand
// R17 - No sequencing with test or loopback
// R18 - Sequencing same for all endpoint kinds
// R19 - Initiator and responder never both
// R20 - Message/response kind from role and direction
// R21 - No checksum check, keep UDP sum correct
// R22 - Responder marks out-of-sequence, loops/copies
// R23 - Sequence field: 32/1/15/16 bit layout
// R24 - Field position is 16-bit payload offset
// R25 - Compare with previous plus one, store
// R26 - Counters wrap; writes load value
module oee_engine
  import oee_pkg::*;
#(
  parameter int CNT_W = OEE_CNT_W
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  input  wire oee_req_type i_req,
  output oee_res_type      o_res
);

  // --------------------
  // Configuration registers
  // --------------------
  logic [OEE_CTRL_WIDTH-1:0] ctrl_q;
  logic [OEE_GEN_W-1:0]      gen_oam_mask_q;
  logic [OEE_GEN_W-1:0]      gen_dat_mask_q;
  logic [OEE_GEN_W-1:0]      gen_pass_mask_q;
  logic [OEE_GEN_W-1:0]      gen_cpu_mask_q;
  logic [OEE_QU_W-1:0]       gen_qu_q;
  logic [OEE_QU_W-1:0]       def_qu_q;
  logic [OEE_QU_W-1:0]       lt_qu_q;
  logic [OEE_QU_W-1:0]       seq_qu_q;
  logic [21:0]               seq_cfg_q;

  // Software writes to configuration
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q          <= '0;
      gen_oam_mask_q  <= '0;
      gen_dat_mask_q  <= '0;
      gen_pass_mask_q <= '0;
      gen_cpu_mask_q  <= '0;
      gen_qu_q        <= '0;
      def_qu_q        <= '0;
      lt_qu_q         <= '0;
      seq_qu_q        <= '0;
      seq_cfg_q       <= '0;
    end else if (i_wr) begin
      case (i_addr)
        OEE_REG_CTRL:     ctrl_q <= i_wdata[OEE_CTRL_WIDTH-1:0];
        OEE_REG_GEN_CNT: begin
          gen_oam_mask_q <= i_wdata[7:0];
          gen_dat_mask_q <= i_wdata[15:8];
        end
        OEE_REG_GEN_MISC: begin
          gen_pass_mask_q <= i_wdata[7:0];
          gen_cpu_mask_q  <= i_wdata[15:8];
        end
        OEE_REG_QUEUES: begin
          gen_qu_q <= i_wdata[3:0];
          def_qu_q <= i_wdata[7:4];
          lt_qu_q  <= i_wdata[11:8];
          seq_qu_q <= i_wdata[15:12];
        end
        OEE_REG_SEQ_CFG:  seq_cfg_q <= i_wdata[21:0];
        default: ;
      endcase
    end
  end

  // --------------------
  // Lookup decode
  // --------------------
  logic       ext_stamp;
  logic       is_dm;
  logic       is_gen;
  logic       is_lt;
  logic       is_unk;
  logic       seq_init;
  logic       seq_resp;
  logic       seq_on;
  logic       is_seq;
  logic       seq_msg;
  logic       seq_rsp;
  logic       blocked;
  logic       oam_cnt;
  logic       dat_cnt;
  logic [31:0] seq_tx_q;
  logic [31:0] seq_rx_q;
  logic       seq_mismatch;

  assign ext_stamp = ctrl_q[OEE_CTRL_EXT_STAMP];
  assign is_dm     = i_req.valid && i_req.pdu == OEE_PDU_ONEWAY && i_req.level_ok && i_req.dmac_ok;
  // Trace frames: generic path, level and address check only
  assign is_lt     = i_req.valid && i_req.pdu == OEE_PDU_GENERIC && (i_req.is_ltm || i_req.is_ltr)
                     && i_req.level_ok && i_req.dmac_ok; // R12
  assign is_gen    = i_req.valid && i_req.pdu == OEE_PDU_GENERIC && !i_req.unknown_op && !is_lt;
  assign is_unk    = i_req.valid && i_req.pdu == OEE_PDU_GENERIC && i_req.unknown_op;
  // Initiator wins if software breaks the exclusive-role contract
  assign seq_init  = seq_cfg_q[OEE_SEQ_INIT]; // R19
  assign seq_resp  = seq_cfg_q[OEE_SEQ_RESP] && !seq_init; // R19
  assign seq_on    = seq_init || seq_resp;
  // Classifier tag, address match and an enabled role select the frame; same for every endpoint kind
  assign is_seq    = i_req.valid && i_req.pdu == OEE_PDU_SEQ && i_req.dmac_ok && seq_on; // R15 R16 R18
  assign seq_msg   = is_seq && ((seq_init && !i_req.is_rx) || (seq_resp && i_req.is_rx)); // R20
  assign seq_rsp   = is_seq && ((seq_resp && !i_req.is_rx) || (seq_init && i_req.is_rx)); // R20
  assign seq_mismatch = i_req.seq_in != seq_rx_q + 32'h0000_0001; // R25
  // Same-level generic frames pass only where the pass mask says so
  assign blocked   = i_req.valid && i_req.pdu != OEE_PDU_SEQ && i_req.pdu != OEE_PDU_DATA && i_req.level_eq
                     && !(is_gen && gen_pass_mask_q[i_req.gen_idx]); // R9

  // Count qualifiers
  always_comb begin
    oam_cnt = 1'b0;
    dat_cnt = 1'b0;
    if (is_dm) begin
      oam_cnt = ctrl_q[OEE_CTRL_DM_OAM_CNT]; // R3
      dat_cnt = ctrl_q[OEE_CTRL_DM_DAT_CNT]; // R3
    end else if (is_lt) begin
      oam_cnt = i_req.is_ltm ? ctrl_q[OEE_CTRL_LTM_OAM_CNT] : ctrl_q[OEE_CTRL_LTR_OAM_CNT]; // R14
      dat_cnt = i_req.is_ltm ? ctrl_q[OEE_CTRL_LTM_DAT_CNT] : ctrl_q[OEE_CTRL_LTR_DAT_CNT]; // R14
    end else if (is_gen) begin
      oam_cnt = gen_oam_mask_q[i_req.gen_idx]; // R8
      dat_cnt = gen_dat_mask_q[i_req.gen_idx]; // R8
    end else if (is_unk) begin
      oam_cnt = ctrl_q[OEE_CTRL_UNK_OAM_CNT]; // R8
      dat_cnt = ctrl_q[OEE_CTRL_UNK_DAT_CNT]; // R8
    end
  end

  // --------------------
  // Sticky flags: hardware set beats software clear
  // --------------------
  logic [OEE_STK_WIDTH-1:0] stk_q;
  logic [OEE_GEN_W-1:0]     gen_stk_q;
  logic [OEE_STK_WIDTH-1:0] stk_set;
  logic [OEE_GEN_W-1:0]     gen_set;

  always_comb begin
    stk_set = '0;
    gen_set = '0;
    if (i_req.is_rx) begin
      stk_set[OEE_STK_DM]    = is_dm; // R5
      stk_set[OEE_STK_UNK]   = is_unk; // R10
      stk_set[OEE_STK_LTM]   = is_lt && i_req.is_ltm; // R14
      stk_set[OEE_STK_LTR]   = is_lt && i_req.is_ltr; // R14
      stk_set[OEE_STK_SEQ]   = is_seq;
      stk_set[OEE_STK_SEQER] = is_seq && seq_mismatch; // R22
      if (is_gen)
        gen_set[i_req.gen_idx] = 1'b1; // R10
    end
  end

  // Write one to clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stk_q     <= '0;
      gen_stk_q <= '0;
    end else begin
      stk_q     <= (stk_q & ~((i_wr && i_addr == OEE_REG_STICKY) ? i_wdata[OEE_STK_WIDTH-1:0] : '0)) | stk_set;
      gen_stk_q <= (gen_stk_q & ~((i_wr && i_addr == OEE_REG_GEN_STKY) ? i_wdata[7:0] : '0)) | gen_set;
    end
  end

  // --------------------
  // Counters: wrap on overflow, software write loads
  // --------------------
  logic [CNT_W-1:0] dmtx_q;
  logic [CNT_W-1:0] dmrx_q;
  logic [CNT_W-1:0] oamtx_q;
  logic [CNT_W-1:0] oamrx_q;
  logic [CNT_W-1:0] dattx_q;
  logic [CNT_W-1:0] datrx_q;
  logic [CNT_W-1:0] seqerr_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dmtx_q   <= '0;
      dmrx_q   <= '0;
      oamtx_q  <= '0;
      oamrx_q  <= '0;
      dattx_q  <= '0;
      datrx_q  <= '0;
      seqerr_q <= '0;
    end else begin
      if (i_wr && i_addr == OEE_REG_DMTX_CNT) dmtx_q <= i_wdata[CNT_W-1:0]; // R26
      else if (is_dm && !i_req.is_rx) dmtx_q <= dmtx_q + 1'b1; // R4
      if (i_wr && i_addr == OEE_REG_DMRX_CNT) dmrx_q <= i_wdata[CNT_W-1:0]; // R26
      else if (is_dm && i_req.is_rx) dmrx_q <= dmrx_q + 1'b1; // R5
      if (i_wr && i_addr == OEE_REG_OAMTX_CNT) oamtx_q <= i_wdata[CNT_W-1:0];
      else if (oam_cnt && !i_req.is_rx) oamtx_q <= oamtx_q + 1'b1; // R26
      if (i_wr && i_addr == OEE_REG_OAMRX_CNT) oamrx_q <= i_wdata[CNT_W-1:0];
      else if (oam_cnt && i_req.is_rx) oamrx_q <= oamrx_q + 1'b1;
      if (i_wr && i_addr == OEE_REG_DATTX_CNT) dattx_q <= i_wdata[CNT_W-1:0];
      else if (dat_cnt && !i_req.is_rx) dattx_q <= dattx_q + 1'b1;
      if (i_wr && i_addr == OEE_REG_DATRX_CNT) datrx_q <= i_wdata[CNT_W-1:0];
      else if (dat_cnt && i_req.is_rx) datrx_q <= datrx_q + 1'b1;
      if (i_wr && i_addr == OEE_REG_SEQ_ERR) seqerr_q <= i_wdata[CNT_W-1:0];
      else if (is_seq && i_req.is_rx && seq_mismatch) seqerr_q <= seqerr_q + 1'b1;
    end
  end

  // Sequence reference numbers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seq_tx_q <= OEE_RST_WORD;
      seq_rx_q <= OEE_RST_WORD;
    end else begin
      if (i_wr && i_addr == OEE_REG_SEQ_TX) seq_tx_q <= i_wdata;
      else if (seq_msg && !i_req.is_rx) seq_tx_q <= seq_tx_q + 32'h0000_0001;
      if (i_wr && i_addr == OEE_REG_SEQ_RX) seq_rx_q <= i_wdata;
      else if (is_seq && i_req.is_rx) seq_rx_q <= i_req.seq_in; // R25
    end
  end

  // --------------------
  // Lookup result
  // --------------------
  oee_res_type res_d;
  logic [15:0] comp_tx;

  // Compensation cancels inserted words in the ones-complement sum
  function automatic logic [15:0] oee_comp(input logic [31:0] val, input logic flag);
    logic [17:0] s;
    s = {2'b00, val[31:16]} + {2'b00, val[15:0]} + {2'b00, flag, 15'h0000};
    s = {2'b00, s[15:0]} + {16'h0000, s[17:16]};
    return ~s[15:0];
  endfunction

  assign comp_tx = oee_comp(seq_tx_q, 1'b0); // R21

  always_comb begin
    res_d              = '0;
    res_d.valid        = i_req.valid;
    res_d.stamp        = i_req.stamp;
    res_d.discard      = blocked; // R9
    res_d.seq_offset   = seq_cfg_q[15:0]; // R24
    res_d.seq_kind_msg = seq_msg;
    res_d.seq_kind_rsp = seq_rsp;
    // Disabled or external stamping leaves the frame alone
    if (is_dm && ctrl_q[OEE_CTRL_DM_HW_EN] && !ext_stamp) begin // R1 R2
      res_d.wr_tx_stamp = !i_req.is_rx; // R4
      res_d.wr_rx_stamp = i_req.is_rx; // R5
    end
    if (is_dm && i_req.is_rx && ctrl_q[OEE_CTRL_DM_CPU]) begin
      res_d.cpu_copy  = 1'b1; // R6
      res_d.cpu_queue = def_qu_q;
    end
    // Generic and unknown: copy only, never modified, nothing on transmit
    if (i_req.is_rx && is_gen && gen_cpu_mask_q[i_req.gen_idx]) begin // R7
      res_d.cpu_copy  = 1'b1; // R11
      res_d.cpu_queue = gen_qu_q; // R11
    end
    if (i_req.is_rx && is_unk && ctrl_q[OEE_CTRL_UNK_CPU]) begin
      res_d.cpu_copy  = 1'b1; // R11
      res_d.cpu_queue = def_qu_q; // R11
    end
    if (i_req.is_rx && is_lt && ((i_req.is_ltm && ctrl_q[OEE_CTRL_LTM_CPU])
        || (i_req.is_ltr && ctrl_q[OEE_CTRL_LTR_CPU]))) begin
      res_d.cpu_copy  = 1'b1; // R13
      res_d.cpu_queue = lt_qu_q; // R13
    end
    // Initiator stamps the sequence number; field layout 32/1/15/16
    if (seq_msg && !i_req.is_rx) begin
      res_d.wr_seq      = 1'b1; // R23
      res_d.seq_no      = seq_tx_q;
      res_d.wr_chk_comp = seq_cfg_q[OEE_SEQ_UPD_CHK] && i_req.is_udp; // R21
      res_d.chk_comp    = comp_tx;
    end
    // Responder marks the error and may loop and copy
    if (seq_msg && i_req.is_rx) begin
      res_d.set_fwd_err = seq_mismatch; // R22
      res_d.wr_chk_comp = seq_mismatch && seq_cfg_q[OEE_SEQ_UPD_CHK] && i_req.is_udp;
      res_d.chk_comp    = oee_comp(i_req.seq_in, 1'b1);
      res_d.loop_back   = seq_cfg_q[OEE_SEQ_LOOP]; // R22
      res_d.cpu_copy    = seq_cfg_q[OEE_SEQ_CPU] || (seq_mismatch && seq_cfg_q[OEE_SEQ_ERR_CPU]); // R22
      res_d.cpu_queue   = seq_qu_q;
    end
    if (seq_rsp && i_req.is_rx) begin
      res_d.cpu_copy  = seq_cfg_q[OEE_SEQ_CPU] || (seq_mismatch && seq_cfg_q[OEE_SEQ_ERR_CPU]);
      res_d.cpu_queue = seq_qu_q;
    end
  end

  // Registered result toward the modification points
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_res <= '0;
    else       o_res <= res_d;
  end

  // --------------------
  // Read port
  // --------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= OEE_RST_WORD;
    end else if (i_rd) begin
      case (i_addr)
        OEE_REG_CTRL:      o_rdata <= 32'(ctrl_q);
        OEE_REG_GEN_CNT:   o_rdata <= {16'h0000, gen_dat_mask_q, gen_oam_mask_q};
        OEE_REG_GEN_MISC:  o_rdata <= {16'h0000, gen_cpu_mask_q, gen_pass_mask_q};
        OEE_REG_QUEUES:    o_rdata <= {16'h0000, seq_qu_q, lt_qu_q, def_qu_q, gen_qu_q};
        OEE_REG_SEQ_CFG:   o_rdata <= {10'h000, seq_cfg_q};
        OEE_REG_STICKY:    o_rdata <= 32'(stk_q);
        OEE_REG_GEN_STKY:  o_rdata <= 32'(gen_stk_q);
        OEE_REG_DMTX_CNT:  o_rdata <= 32'(dmtx_q);
        OEE_REG_DMRX_CNT:  o_rdata <= 32'(dmrx_q);
        OEE_REG_OAMTX_CNT: o_rdata <= 32'(oamtx_q);
        OEE_REG_OAMRX_CNT: o_rdata <= 32'(oamrx_q);
        OEE_REG_DATTX_CNT: o_rdata <= 32'(dattx_q);
        OEE_REG_DATRX_CNT: o_rdata <= 32'(datrx_q);
        OEE_REG_SEQ_TX:    o_rdata <= seq_tx_q;
        OEE_REG_SEQ_RX:    o_rdata <= seq_rx_q;
        OEE_REG_SEQ_ERR:   o_rdata <= 32'(seqerr_q);
        default:           o_rdata <= OEE_RST_WORD;
      endcase
    end else begin
      o_rdata <= OEE_RST_WORD;
    end
  end

endmodule

// File: rtl/oee_pkg.sv
// Purpose: Constants and carriers of the OAM endpoint engine
// Assumes: One core clock, registers reached over a plain strobe port
// Notes:   Register offsets are word indexes on the local port
package oee_pkg;

  // --------------------
  // Register offsets
  // --------------------
  localparam logic [7:0] OEE_REG_CTRL      = 8'h00;
  localparam logic [7:0] OEE_REG_GEN_CNT   = 8'h01;
  localparam logic [7:0] OEE_REG_GEN_MISC  = 8'h02;
  localparam logic [7:0] OEE_REG_QUEUES    = 8'h03;
  localparam logic [7:0] OEE_REG_SEQ_CFG   = 8'h04;
  localparam logic [7:0] OEE_REG_STICKY    = 8'h05;
  localparam logic [7:0] OEE_REG_GEN_STKY  = 8'h06;
  localparam logic [7:0] OEE_REG_DMTX_CNT  = 8'h07;
  localparam logic [7:0] OEE_REG_DMRX_CNT  = 8'h08;
  localparam logic [7:0] OEE_REG_OAMTX_CNT = 8'h09;
  localparam logic [7:0] OEE_REG_OAMRX_CNT = 8'h0a;
  localparam logic [7:0] OEE_REG_DATTX_CNT = 8'h0b;
  localparam logic [7:0] OEE_REG_DATRX_CNT = 8'h0c;
  localparam logic [7:0] OEE_REG_SEQ_TX    = 8'h0d;
  localparam logic [7:0] OEE_REG_SEQ_RX    = 8'h0e;
  localparam logic [7:0] OEE_REG_SEQ_ERR   = 8'h0f;

  // --------------------
  // Control register fields
  // --------------------
  localparam int OEE_CTRL_EXT_STAMP   = 0;
  localparam int OEE_CTRL_DM_HW_EN    = 1;
  localparam int OEE_CTRL_DM_OAM_CNT  = 2;
  localparam int OEE_CTRL_DM_DAT_CNT  = 3;
  localparam int OEE_CTRL_DM_CPU      = 4;
  localparam int OEE_CTRL_UNK_OAM_CNT = 5;
  localparam int OEE_CTRL_UNK_DAT_CNT = 6;
  localparam int OEE_CTRL_UNK_CPU     = 7;
  localparam int OEE_CTRL_LTM_CPU     = 8;
  localparam int OEE_CTRL_LTR_CPU     = 9;
  localparam int OEE_CTRL_LTM_OAM_CNT = 10;
  localparam int OEE_CTRL_LTR_OAM_CNT = 11;
  localparam int OEE_CTRL_LTM_DAT_CNT = 12;
  localparam int OEE_CTRL_LTR_DAT_CNT = 13;
  localparam int OEE_CTRL_WIDTH       = 14;

  // Sticky register fields
  localparam int OEE_STK_DM    = 0;
  localparam int OEE_STK_UNK   = 1;
  localparam int OEE_STK_LTM   = 2;
  localparam int OEE_STK_LTR   = 3;
  localparam int OEE_STK_SEQ   = 4;
  localparam int OEE_STK_SEQER = 5;
  localparam int OEE_STK_WIDTH = 6;

  // Sequence config fields
  localparam int OEE_SEQ_OFS_LSB = 0;
  localparam int OEE_SEQ_INIT    = 16;
  localparam int OEE_SEQ_RESP    = 17;
  localparam int OEE_SEQ_UPD_CHK = 18;
  localparam int OEE_SEQ_LOOP    = 19;
  localparam int OEE_SEQ_CPU     = 20;
  localparam int OEE_SEQ_ERR_CPU = 21;

  // Widths and reset values
  localparam int          OEE_GEN_W    = 8;
  localparam int          OEE_QU_W     = 4;
  localparam int          OEE_CNT_W    = 32;
  localparam logic [31:0] OEE_RST_WORD = 32'h0000_0000;

  // Frame protocol constants
  localparam logic [15:0] OEE_SEQ_ETYPE = 16'h8880;
  localparam logic [15:0] OEE_SEQ_PROTO = 16'h0008;

  // --------------------
  // Types
  // --------------------
  typedef enum logic [3:0] {
    OEE_PDU_DATA    = 4'h1,
    OEE_PDU_ONEWAY  = 4'h2,
    OEE_PDU_GENERIC = 4'h4,
    OEE_PDU_SEQ     = 4'h8
  } oee_pdu_type;

  // Lookup request from the pipeline
  typedef struct packed {
    logic        valid;
    logic        is_rx;
    oee_pdu_type pdu;
    logic        unknown_op;
    logic        is_ltm;
    logic        is_ltr;
    logic [2:0]  gen_idx;
    logic        level_eq;
    logic        level_ok;
    logic        dmac_ok;
    logic        is_udp;
    logic [63:0] stamp;
    logic [31:0] seq_in;
  } oee_req_type;

  // Lookup result to the modification points
  typedef struct packed {
    logic                 valid;
    logic                 discard;
    logic                 cpu_copy;
    logic [OEE_QU_W-1:0]  cpu_queue;
    logic                 wr_tx_stamp;
    logic                 wr_rx_stamp;
    logic [63:0]          stamp;
    logic                 seq_kind_msg;
    logic                 seq_kind_rsp;
    logic                 wr_seq;
    logic [31:0]          seq_no;
    logic                 set_fwd_err;
    logic                 wr_chk_comp;
    logic [15:0]          chk_comp;
    logic [15:0]          seq_offset;
    logic                 loop_back;
  } oee_res_type;

endpackage

// File: tb/oee_engine_asserts.sv
// Purpose: Port-level checks of the endpoint engine lookup results
// Assumes: Config is shadowed from register writes seen at the port
// Notes:   Shadows hold whole written words
module oee_engine_asserts
  import oee_pkg::*;
#(
  parameter int CNT_W = OEE_CNT_W
) (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire oee_req_type i_req,
  input wire oee_res_type o_res
);
  logic [31:0] ctrl_q, misc_q, qu_q, seq_q;
  // Shadow of config, old value seen by a lookup on the write edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {ctrl_q, misc_q, qu_q, seq_q} <= '0;
    end else if (i_wr) begin
      if (i_addr == OEE_REG_CTRL) ctrl_q <= i_wdata;
      if (i_addr == OEE_REG_GEN_MISC) misc_q <= i_wdata;
      if (i_addr == OEE_REG_QUEUES) qu_q <= i_wdata;
      if (i_addr == OEE_REG_SEQ_CFG) seq_q <= i_wdata;
    end
  end
  // --------------------
  // Properties
  // --------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ok;
    i_req.valid && i_req.level_ok && i_req.dmac_ok && !i_req.level_eq;
  endsequence
  sequence s_gen;
    i_req.valid && i_req.pdu == OEE_PDU_GENERIC;
  endsequence
  sequence s_dm;
    s_ok ##0 (i_req.pdu == OEE_PDU_ONEWAY);
  endsequence
  property p_ext;
    s_dm ##0 ctrl_q[OEE_CTRL_EXT_STAMP] |=> !(o_res.wr_tx_stamp || o_res.wr_rx_stamp);
  endproperty
  a_ext: assert property (p_ext) else $error("stamp written with external stamping");
  property p_hw_off;
    s_dm ##0 !ctrl_q[OEE_CTRL_DM_HW_EN] |=> !(o_res.wr_tx_stamp || o_res.wr_rx_stamp || o_res.wr_seq);
  endproperty
  a_hw_off: assert property (p_hw_off) else $error("delay frame modified while disabled");
  property p_tx_stamp;
    s_dm ##0 (!i_req.is_rx && ctrl_q[OEE_CTRL_DM_HW_EN] && !ctrl_q[OEE_CTRL_EXT_STAMP])
      |=> o_res.wr_tx_stamp && o_res.stamp == $past(i_req.stamp);
  endproperty
  a_tx_stamp: assert property (p_tx_stamp) else $error("transmit stamp missing");
  property p_rx_stamp;
    s_dm ##0 (i_req.is_rx && ctrl_q[OEE_CTRL_DM_HW_EN] && !ctrl_q[OEE_CTRL_EXT_STAMP])
      |=> o_res.wr_rx_stamp && !o_res.wr_tx_stamp;
  endproperty
  a_rx_stamp: assert property (p_rx_stamp) else $error("receive stamp missing");
  property p_dm_copy;
    s_dm ##0 (i_req.is_rx && ctrl_q[OEE_CTRL_DM_CPU]) |=> o_res.cpu_copy && o_res.cpu_queue == $past(qu_q[7:4]);
  endproperty
  a_dm_copy: assert property (p_dm_copy) else $error("delay frame copy wrong");
  property p_gen_nomod;
    s_gen
      |=> !(o_res.wr_tx_stamp || o_res.wr_rx_stamp || o_res.wr_seq || o_res.set_fwd_err || o_res.wr_chk_comp);
  endproperty
  a_gen_nomod: assert property (p_gen_nomod) else $error("generic frame modified");
  property p_gen_tx;
    s_gen ##0 !i_req.is_rx |=> !o_res.cpu_copy;
  endproperty
  a_gen_tx: assert property (p_gen_tx) else $error("generic transmit copied");
  property p_level;
    s_gen ##0 (i_req.level_eq && !i_req.unknown_op && !i_req.is_ltm
      && !i_req.is_ltr && !misc_q[i_req.gen_idx]) |=> o_res.discard;
  endproperty
  a_level: assert property (p_level) else $error("same level frame not blocked");
  property p_trace_q;
    s_ok ##0 s_gen ##0 (i_req.is_rx && i_req.is_ltm && ctrl_q[OEE_CTRL_LTM_CPU])
      |=> o_res.cpu_copy && o_res.cpu_queue == $past(qu_q[11:8]);
  endproperty
  a_trace_q: assert property (p_trace_q) else $error("trace copy queue wrong");
  property p_seq_kind;
    i_req.valid && i_req.dmac_ok && i_req.pdu == OEE_PDU_SEQ && seq_q[OEE_SEQ_INIT] && !i_req.is_rx
      |=> o_res.seq_kind_msg && !o_res.seq_kind_rsp;
  endproperty
  a_seq_kind: assert property (p_seq_kind) else $error("initiator transmit kind wrong");
endmodule

bind oee_engine oee_engine_asserts #(.CNT_W(CNT_W)) u_asserts (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_req, .o_res);

// File: tb/oee_engine_bench.sv
// Purpose: Self-checking bench for the endpoint engine
// Assumes: Drivers queue expectations, a negedge monitor pops them
// Notes:   Result masks ignore fields the rules leave open
module oee_engine_bench;
  import oee_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {oee_res_type v; oee_res_type m;} oee_exp_type;
  logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, go = 0, rd_taken = 0;
  logic [7:0]  i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata, n, t, seed = 32'h7c1b6231;
  logic [2:0]  g;
  oee_req_type i_req, send = '0, r;
  oee_res_type o_res;
  oee_exp_type e, rq[$];
  logic [31:0] dq[$];
  int          failures = 0, tests_run = 0;
  always #2.5 i_clk = ~i_clk;
  oee_engine uut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_req, .o_res);
  oee_pipe_model pipe (.i_clk, .i_rst, .i_go(go), .i_send(send), .o_req(i_req));
  // --------------------
  // Drivers, monitor and compare
  // --------------------
  task check(input string what, input logic [255:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    dq.push_back(x);
    @(posedge i_clk) {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_clk) i_rd <= 1'b0;
  endtask
  task look(input oee_req_type q, input oee_exp_type x);
    rq.push_back(x);
    @(posedge i_clk) {send, go} <= {q, 1'b1};
    @(posedge i_clk) go <= 1'b0;
  endtask
  function oee_req_type mk(logic rx, oee_pdu_type p);
    oee_req_type q;
    q = '0;
    {q.valid, q.is_rx, q.pdu, q.level_ok, q.dmac_ok} = {1'b1, rx, p, 2'b11};
    q.stamp = {$random(seed), $random(seed)};
    return q;
  endfunction
  // Masked expectation; queue checked only on copy
  function oee_exp_type ex(logic dis, cp, txs, rxs, logic [3:0] q);
    oee_exp_type x;
    x = '0;
    {x.v.valid, x.v.discard, x.v.cpu_copy, x.v.wr_tx_stamp, x.v.wr_rx_stamp, x.v.cpu_queue} = {1'b1, dis, cp, txs, rxs, q};
    {x.m.valid, x.m.discard, x.m.cpu_copy, x.m.wr_tx_stamp, x.m.wr_rx_stamp, x.m.wr_seq, x.m.set_fwd_err} = '1;
    x.m.cpu_queue = {4{cp}};
    return x;
  endfunction
  // Read data stands only in the cycle after the strobe
  always @(posedge i_clk) rd_taken <= i_rd;
  always @(negedge i_clk) begin
    if (rd_taken) check("rdata", o_rdata, dq.pop_front());
    if (o_res.valid === 1'b1) begin
      e = rq.pop_front();
      check("result", o_res & e.m, e.v & e.m);
    end
  end
  task automatic complete_run;
    $display("counts failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog far past the run length
  initial begin
    #50000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 17; k++) rd((k == 16) ? 8'h40 : k[7:0], OEE_RST_WORD);
    $display("test reset done");
    wr(OEE_REG_QUEUES, 32'h0000_0a53);
    wr(OEE_REG_CTRL, 32'h0000_0016);
    look(mk(0, OEE_PDU_ONEWAY), ex(0, 0, 1, 0, 0));
    look(mk(1, OEE_PDU_ONEWAY), ex(0, 1, 0, 1, 4'h5));
    for (int k = 0; k < 4; k++) rd(OEE_REG_DMTX_CNT + k[7:0], 32'h1);
    rd(OEE_REG_DATRX_CNT, 32'h0);
    rd(OEE_REG_STICKY, 32'h1);
    // External stamping, then processing off with data counting
    for (int k = 0; k < 2; k++) begin
      wr(OEE_REG_CTRL, k ? 32'h18 : 32'h17);
      look(mk(1, OEE_PDU_ONEWAY), ex(0, 1, 0, 0, 4'h5));
      look(mk(0, OEE_PDU_ONEWAY), ex(0, 0, 0, 0, 0));
    end
    rd(OEE_REG_DMRX_CNT, 32'h3);
    rd(OEE_REG_OAMRX_CNT, 32'h2);
    rd(OEE_REG_DATRX_CNT, 32'h1);
    wr(OEE_REG_DMRX_CNT, 32'hffff_ffff);
    look(mk(1, OEE_PDU_ONEWAY), ex(0, 1, 0, 0, 4'h5));
    rd(OEE_REG_DMRX_CNT, 32'h0);
    wr(OEE_REG_STICKY, 32'h3f);
    $display("test delay done");
    // Generic, unknown and trace frames with random masks
    n = $random(seed);
    g = n[2:0];
    wr(OEE_REG_CTRL, 32'h0000_07a0);
    wr(OEE_REG_GEN_CNT, {24'h0, n[15:8]});
    wr(OEE_REG_GEN_MISC, {16'h0, n[23:16], 8'h00});
    r = mk(1, OEE_PDU_GENERIC);
    r.gen_idx = g;
    t = 32'h2 + n[8 + g];
    look(r, ex(0, n[16 + g], 0, 0, 4'h3));
    rd(OEE_REG_OAMRX_CNT, t);
    rd(OEE_REG_GEN_STKY, 32'h1 << g);
    r.is_rx = 1'b0;
    look(r, ex(0, 0, 0, 0, 0));
    r.level_eq = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(OEE_REG_GEN_MISC, {24'h0, {8{k[0]}}});
      look(r, ex(!k[0], 0, 0, 0, 0));
    end
    r = mk(1, OEE_PDU_GENERIC);
    r.unknown_op = 1'b1;
    look(r, ex(0, 1, 0, 0, 4'h5));
    r = mk(1, OEE_PDU_GENERIC);
    r.is_ltm = 1'b1;
    look(r, ex(0, 1, 0, 0, 4'ha));
    {r.is_ltm, r.is_ltr} = 2'b01;
    look(r, ex(0, 1, 0, 0, 4'ha));
    rd(OEE_REG_STICKY, 32'he);
    $display("test generic done");
    // Initiator stamps then responder checks the sequence
    wr(OEE_REG_SEQ_CFG, 32'h0001_0010);
    wr(OEE_REG_SEQ_TX, n);
    e = ex(0, 0, 0, 0, 0);
    {e.v.wr_seq, e.v.seq_kind_msg, e.v.seq_no, e.v.seq_offset} = {2'b11, n, 16'h0010};
    {e.m.seq_kind_msg, e.m.seq_kind_rsp, e.m.seq_no, e.m.seq_offset} = '1;
    look(mk(0, OEE_PDU_SEQ), e);
    rd(OEE_REG_SEQ_TX, n + 32'h1);
    wr(OEE_REG_SEQ_CFG, 32'h002e_0000);
    wr(OEE_REG_SEQ_RX, n);
    wr(OEE_REG_SEQ_ERR, 32'h0);
    r = mk(1, OEE_PDU_SEQ);
    {r.is_udp, r.seq_in} = {1'b1, n + 32'h1};
    e = ex(0, 0, 0, 0, 0);
    {e.v.seq_kind_msg, e.v.loop_back, e.m.loop_back, e.m.seq_kind_msg, e.m.seq_kind_rsp} = '1;
    look(r, e);
    r.seq_in = n + 32'h5;
    {e.v.set_fwd_err, e.v.wr_chk_comp, e.m.wr_chk_comp, e.v.cpu_copy} = '1;
    look(r, e);
    rd(OEE_REG_SEQ_RX, n + 32'h5);
    rd(OEE_REG_SEQ_ERR, 32'h1);
    $display("test sequence done");
    repeat (4) @(posedge i_clk);
    complete_run();
  end
endmodule

// File: tb/oee_pipe_model.sv
// Purpose: Pipeline stand-in that launches classified lookups into the engine
// Assumes: Bench hands one request and a go pulse per lookup
// Notes:   Idle cycles carry scrambled payload with valid low
module oee_pipe_model
  import oee_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,
  input  wire oee_req_type i_send,
  output oee_req_type      o_req
);
  // Stale fields inverted so nothing leans on the last lookup
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req <= '0;
    end else if (i_go) begin
      o_req <= i_send;
    end else begin
      o_req       <= ~o_req;
      o_req.valid <= 1'b0;
    end
  end
endmodule
